// ===== logic/gms_gear.sv
// electronic gear: reference pulses scaled into feedback steps
`timescale 1ns/100ps
module gms_gear (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_load,
  input  wire logic [29:0] i_num,
  input  wire logic [29:0] i_den,
  input  wire logic        i_run,
  input  wire logic        i_ref_pulse,
  input  wire logic        i_ref_dir,
  output logic             o_step,
  output logic             o_dir,
  output logic             o_err
);
  localparam int unsigned W = gms_pkg::GEAR_W;

  logic [W-1:0]        num_ff;
  logic [W-1:0]        den_ff;
  logic signed [W+1:0] acc_ff;
  logic signed [W+1:0] nxt_acc;
  logic signed [15:0]  pend_ff;
  logic signed [15:0]  nxt_pend;
  logic                step_ff;
  logic                nxt_step;
  logic                dir_ff;
  logic                nxt_dir;
  logic                err_ff;

  wire signed [W+1:0] num_s   = $signed({2'b00, num_ff});
  wire signed [W+1:0] den_s   = $signed({2'b00, den_ff});
  wire [41:0]         lo_prod = {12'h000, num_ff} * gms_pkg::RATIO_LO_MUL;
  wire [41:0]         hi_prod = {12'h000, den_ff} * gms_pkg::RATIO_HI_MUL;
  // ratio bounds 0.001..4000 checked by cross-multiplying num by 1000 and den by 4000
  // a zero denominator with a zero numerator slips past both products, so it is caught alone
  wire ratio_bad = (den_ff == '0) || (lo_prod < {12'h000, den_ff}) ||
                   ({12'h000, num_ff} > hi_prod);

  // signed remainder keeps the ratio exact across direction reversals
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_pend = pend_ff;
    nxt_step = 1'b0;
    nxt_dir  = dir_ff;
    if (i_run) begin
      if (acc_ff >= den_s) begin
        nxt_acc  = acc_ff - den_s;
        nxt_step = 1'b1;
        nxt_dir  = 1'b1;
      end else if (acc_ff <= -den_s) begin
        nxt_acc  = acc_ff + den_s;
        nxt_step = 1'b1;
        nxt_dir  = 1'b0;
      end else if (pend_ff > 16'sh0000) begin
        nxt_acc  = acc_ff + num_s;
        nxt_pend = pend_ff - 16'sh0001;
      end else if (pend_ff < 16'sh0000) begin
        nxt_acc  = acc_ff - num_s;
        nxt_pend = pend_ff + 16'sh0001;
      end
      // saturating: a burst beyond the counter is dropped, not wrapped
      if (i_ref_pulse && i_ref_dir && nxt_pend != gms_pkg::PEND_MAX) begin
        nxt_pend = nxt_pend + 16'sh0001;
      end else if (i_ref_pulse && !i_ref_dir &&
                   nxt_pend != gms_pkg::PEND_MIN) begin
        nxt_pend = nxt_pend - 16'sh0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      num_ff  <= gms_pkg::GEAR_NUM_RST;
      den_ff  <= gms_pkg::GEAR_DEN_RST;
      acc_ff  <= '0;
      pend_ff <= '0;
      step_ff <= 1'b0;
      dir_ff  <= 1'b1;
      err_ff  <= 1'b0;
    end else if (i_load) begin
      num_ff  <= i_num;
      den_ff  <= i_den;
      acc_ff  <= '0;
      pend_ff <= '0;
      step_ff <= 1'b0;
      err_ff  <= err_ff;
    end else begin
      acc_ff  <= nxt_acc;
      pend_ff <= nxt_pend;
      step_ff <= nxt_step;
      dir_ff  <= nxt_dir;
      err_ff  <= ratio_bad;
    end
  end

  assign o_step = step_ff;
  assign o_dir  = dir_ff;
  assign o_err  = err_ff;

  chk_gear_halt: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_run && !i_load |=> !o_step)
    else $error("gear stepped while halted");
  chk_rem_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    i_run && !i_load && !o_err && acc_ff < den_s && acc_ff > -den_s &&
    pend_ff == 16'sh0000 |=> !o_step)
    else $error("gear stepped without remainder");
endmodule : gms_gear

// ===== logic/gms_pkg.sv
// constants and types shared by the gear scaler and motorless test block
// Summary of operation
// - scale each reference unit by numerator over denominator
// - ratio outside 0.001..4000 raises alarm, halts motion
// - select digit 0 enables motorless test after restart
// - select digit 2 picks incremental or absolute scale
// - motorless test simulates motion and feedback internally
// - motorless test blocks regeneration, dynamic brake, brake
// - real direction reported in test only with motor connected
// - link lost mid test keeps motor-absent function set
// - tuning, vibration, polarity functions refused during test
// - reset, offset, origin functions need a motor during test
// - history, jog, init, reset, id functions always allowed
package gms_pkg;
  localparam int unsigned GEAR_W = 30;

  localparam logic [7:0] OFS_GEAR_NUM = 8'h00;
  localparam logic [7:0] OFS_GEAR_DEN = 8'h04;
  localparam logic [7:0] OFS_APP_SEL  = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_FN_REQ   = 8'h14;

  localparam logic [29:0] GEAR_NUM_RST = 30'h0000_0004;
  localparam logic [29:0] GEAR_DEN_RST = 30'h0000_0001;
  localparam logic [15:0] APP_SEL_RST  = 16'h0000;

  localparam int unsigned SEL_TEST_LSB  = 0;
  localparam int unsigned SEL_SCALE_LSB = 8;
  localparam logic [3:0]  SEL_DIGIT_ON  = 4'h1;
  localparam int unsigned CTRL_RESTART  = 0;

  localparam int unsigned ST_TEST    = 0;
  localparam int unsigned ST_ABS     = 1;
  localparam int unsigned ST_GEARERR = 2;
  localparam int unsigned ST_MOTOR   = 3;
  localparam int unsigned ST_LOST    = 4;
  localparam int unsigned ST_MODE    = 5;

  localparam logic [41:0] RATIO_LO_MUL = 42'h000_0000_03E8;
  localparam logic [41:0] RATIO_HI_MUL = 42'h000_0000_0FA0;
  localparam logic signed [15:0] PEND_MAX = 16'sh7FFF;
  localparam logic signed [15:0] PEND_MIN = -16'sh7FFF;

  localparam logic [11:0] FN_TUNE_LEVEL = 12'h200;
  localparam logic [11:0] FN_TUNE_LAST  = 12'h207;
  localparam logic [11:0] FN_VIB_INIT   = 12'h01B;
  localparam logic [11:0] FN_POLARITY   = 12'h080;
  localparam logic [11:0] FN_MULTITURN  = 12'h008;
  localparam logic [11:0] FN_CUR_OFS_AU = 12'h00E;
  localparam logic [11:0] FN_CUR_OFS_MN = 12'h00F;
  localparam logic [11:0] FN_ORIGIN_SET = 12'h020;

  localparam logic [1:0] FN_RES_IDLE  = 2'h0;
  localparam logic [1:0] FN_RES_START = 2'h1;
  localparam logic [1:0] FN_RES_NOOP  = 2'h2;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_TEST   = 2'b01,
    MD_ALARM  = 2'b10
  } gms_mode_e;
endpackage : gms_pkg

// ===== logic/gms_top.sv
// gear scaler with motorless test mode, apb register slave
`timescale 1ns/100ps
module gms_top (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ref_pulse,
  input  wire logic        i_ref_dir,
  input  wire logic        i_enc_link,
  input  wire logic        i_enc_dir,
  input  wire logic        i_regen_req,
  input  wire logic        i_dbrake_req,
  input  wire logic        i_brake_req,
  output logic             o_fb_step,
  output logic             o_fb_dir,
  output logic             o_sim_active,
  output logic             o_scale_abs,
  output logic             o_alarm,
  output logic             o_drive_en,
  output logic             o_regen_en,
  output logic             o_dbrake_en,
  output logic             o_brake_out,
  output logic             o_dir_valid,
  output logic             o_dir,
  output logic             o_fn_start,
  output logic [11:0]      o_fn_code
);
  // pin synchronisers: ref pulse, ref dir, encoder link, encoder dir
  logic [3:0]  sync1_ff;
  logic [3:0]  sync2_ff;
  logic        ref_prev_ff;
  logic [29:0] num_ff;
  logic [29:0] den_ff;
  logic [15:0] sel_ff;
  logic        test_ff;
  logic        abs_ff;
  logic        link_start_ff;
  logic        link_lost_ff;
  logic        restart_ff;
  gms_pkg::gms_mode_e mode_ff;
  gms_pkg::gms_mode_e nxt_mode;
  logic [1:0]  fn_res_ff;
  logic [11:0] fn_code_ff;
  logic        fn_start_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        alarm_ff;
  logic        drive_ff;
  logic        regen_ff;
  logic        dbrake_ff;
  logic        brake_ff;
  logic        dir_valid_ff;
  logic        dir_ff;
  logic        gear_step;
  logic        gear_dir;
  logic        gear_err;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {i_enc_dir, i_enc_link, i_ref_dir, i_ref_pulse};
      sync2_ff <= sync1_ff;
    end
  end

  wire ref_lvl  = sync2_ff[0];
  wire ref_dir  = sync2_ff[1];
  wire link_lvl = sync2_ff[2];
  wire enc_dir  = sync2_ff[3];
  wire ref_edge = ref_lvl && !ref_prev_ff;

  // apb decode; write lands on the edge that completes the transfer
  wire access   = i_psel && i_penable && !pready_ff;
  wire finish   = i_psel && i_penable && pready_ff;
  wire wr_fire  = finish && i_pwrite;
  wire hit_num  = i_paddr == gms_pkg::OFS_GEAR_NUM;
  wire hit_den  = i_paddr == gms_pkg::OFS_GEAR_DEN;
  wire hit_sel  = i_paddr == gms_pkg::OFS_APP_SEL;
  wire hit_ctrl = i_paddr == gms_pkg::OFS_CTRL;
  wire hit_stat = i_paddr == gms_pkg::OFS_STATUS;
  wire hit_fn   = i_paddr == gms_pkg::OFS_FN_REQ;
  wire hit_any  = hit_num || hit_den || hit_sel || hit_ctrl ||
                  hit_stat || hit_fn;
  wire restart  = wr_fire && hit_ctrl && i_pwdata[gms_pkg::CTRL_RESTART];
  wire fn_req   = wr_fire && hit_fn;
  wire [11:0] req_code = i_pwdata[11:0];

  wire [3:0] test_dig  = sel_ff[gms_pkg::SEL_TEST_LSB +: 4];
  wire [3:0] scale_dig = sel_ff[gms_pkg::SEL_SCALE_LSB +: 4];

  // motor counts as present only if linked at restart and now, and, in test, never dropped since restart
  wire motor_ok = link_lvl && link_start_ff && !link_lost_ff;

  wire cls_never = (req_code >= gms_pkg::FN_TUNE_LEVEL &&
                    req_code <= gms_pkg::FN_TUNE_LAST) ||
                   req_code == gms_pkg::FN_VIB_INIT ||
                   req_code == gms_pkg::FN_POLARITY;
  wire cls_motor = req_code == gms_pkg::FN_MULTITURN ||
                   req_code == gms_pkg::FN_CUR_OFS_AU ||
                   req_code == gms_pkg::FN_CUR_OFS_MN ||
                   req_code == gms_pkg::FN_ORIGIN_SET;
  wire fn_ok = !test_ff || (!cls_never && (!cls_motor || motor_ok));

  wire [31:0] stat_word = {25'h000_0000, mode_ff, link_lost_ff,
                           motor_ok, gear_err, abs_ff, test_ff};
  wire [31:0] rd_data =
    hit_num  ? {2'b00, num_ff} :
    hit_den  ? {2'b00, den_ff} :
    hit_sel  ? {16'h0000, sel_ff} :
    hit_stat ? stat_word :
    hit_fn   ? {18'h0_0000, fn_res_ff, fn_code_ff} : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access && !hit_any;
      if (access) begin
        prdata_ff <= rd_data;
      end
    end
  end

  // settings are shadows; they act only when restart copies them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      num_ff <= gms_pkg::GEAR_NUM_RST;
      den_ff <= gms_pkg::GEAR_DEN_RST;
      sel_ff <= gms_pkg::APP_SEL_RST;
    end else if (wr_fire) begin
      if (hit_num) num_ff <= i_pwdata[29:0];
      if (hit_den) den_ff <= i_pwdata[29:0];
      if (hit_sel) sel_ff <= i_pwdata[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      test_ff    <= 1'b0;
      abs_ff     <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= restart;
      if (restart) begin
        test_ff <= test_dig == gms_pkg::SEL_DIGIT_ON;
        abs_ff  <= scale_dig == gms_pkg::SEL_DIGIT_ON;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      link_start_ff <= 1'b0;
      link_lost_ff  <= 1'b0;
      ref_prev_ff   <= 1'b0;
    end else begin
      ref_prev_ff <= ref_lvl;
      if (restart) begin
        link_start_ff <= link_lvl;
        link_lost_ff  <= 1'b0;
      end else if (test_ff && !link_lvl) begin
        link_lost_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      gms_pkg::MD_NORMAL,
      gms_pkg::MD_TEST,
      gms_pkg::MD_ALARM: begin
        if (gear_err) begin
          nxt_mode = gms_pkg::MD_ALARM;
        end else if (test_ff) begin
          nxt_mode = gms_pkg::MD_TEST;
        end else begin
          nxt_mode = gms_pkg::MD_NORMAL;
        end
      end
      default: nxt_mode = gms_pkg::MD_NORMAL;
    endcase
  end

  // in test the motor bridge stays off; gear feedback is the motion
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_ff      <= gms_pkg::MD_NORMAL;
      alarm_ff     <= 1'b0;
      drive_ff     <= 1'b0;
      regen_ff     <= 1'b0;
      dbrake_ff    <= 1'b0;
      brake_ff     <= 1'b0;
      dir_valid_ff <= 1'b0;
      dir_ff       <= 1'b0;
    end else begin
      mode_ff      <= nxt_mode;
      alarm_ff     <= nxt_mode == gms_pkg::MD_ALARM;
      drive_ff     <= nxt_mode == gms_pkg::MD_NORMAL;
      regen_ff     <= i_regen_req && !test_ff;
      dbrake_ff    <= i_dbrake_req && !test_ff;
      brake_ff     <= i_brake_req && !test_ff;
      dir_valid_ff <= !test_ff || motor_ok;
      dir_ff       <= enc_dir && (!test_ff || motor_ok);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fn_res_ff   <= gms_pkg::FN_RES_IDLE;
      fn_code_ff  <= 12'h000;
      fn_start_ff <= 1'b0;
    end else begin
      fn_start_ff <= fn_req && fn_ok;
      if (fn_req && fn_ok) begin
        fn_res_ff  <= gms_pkg::FN_RES_START;
        fn_code_ff <= req_code;
      end else if (fn_req) begin
        fn_res_ff <= gms_pkg::FN_RES_NOOP;
      end
    end
  end

  gms_gear u_gear (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_load      (restart_ff),
    .i_num       (num_ff),
    .i_den       (den_ff),
    .i_run       (mode_ff != gms_pkg::MD_ALARM),
    .i_ref_pulse (ref_edge),
    .i_ref_dir   (ref_dir),
    .o_step      (gear_step),
    .o_dir       (gear_dir),
    .o_err       (gear_err)
  );

  assign o_prdata     = prdata_ff;
  assign o_pready     = pready_ff;
  assign o_pslverr    = pslverr_ff;
  assign o_fb_step    = gear_step;
  assign o_fb_dir     = gear_dir;
  assign o_sim_active = test_ff;
  assign o_scale_abs  = abs_ff;
  assign o_alarm      = alarm_ff;
  assign o_drive_en   = drive_ff;
  assign o_regen_en   = regen_ff;
  assign o_dbrake_en  = dbrake_ff;
  assign o_brake_out  = brake_ff;
  assign o_dir_valid  = dir_valid_ff;
  assign o_dir        = dir_ff;
  assign o_fn_start   = fn_start_ff;
  assign o_fn_code    = fn_code_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_fn_refused;
    fn_req && test_ff && (cls_never || (cls_motor && !motor_ok));
  endsequence
  sequence s_noop_shown;
    !o_fn_start && fn_res_ff == gms_pkg::FN_RES_NOOP;
  endsequence

  chk_test_latch: assert property (restart |=>
    test_ff == (sel_ff[gms_pkg::SEL_TEST_LSB +: 4] == 4'h1))
    else $error("test enable not taken at restart");
  chk_test_hold: assert property (!restart |=> $stable(test_ff))
    else $error("test enable changed without restart");
  chk_scale_hold: assert property (!restart |=> $stable(abs_ff))
    else $error("scale type changed without restart");
  chk_alarm_path: assert property (gear_err |=> mode_ff ==
    gms_pkg::MD_ALARM && o_alarm && !o_drive_en)
    else $error("gear error did not raise alarm");
  chk_brake_block: assert property (test_ff && $past(test_ff) |->
    !o_regen_en && !o_dbrake_en && !o_brake_out)
    else $error("brake path active in test");
  chk_sim_drive: assert property (test_ff && $past(test_ff) |->
    !o_drive_en)
    else $error("motor driven during test");
  chk_dir_hidden: assert property (test_ff && !motor_ok |=>
    !o_dir_valid && !o_dir)
    else $error("direction shown without motor");
  chk_link_sticky: assert property (link_lost_ff && !restart |=>
    link_lost_ff && !motor_ok)
    else $error("lost link released motor functions");
  chk_fn_refuse: assert property (s_fn_refused |=> s_noop_shown)
    else $error("refused function started");
  chk_fn_motor: assert property (fn_req && test_ff && cls_motor &&
    motor_ok |=> o_fn_start)
    else $error("motor function refused with motor");
  chk_fn_free: assert property (fn_req && !cls_never && !cls_motor
    |=> o_fn_start ##1 !o_fn_start)
    else $error("free function not started once");
  chk_noop_keep: assert property (s_fn_refused |=>
    $stable(o_fn_code) && $stable(mode_ff))
    else $error("refused function changed state");

  // one wait state: pready is a single-cycle pulse per access
  chk_apb_wait: assert property (access |=> o_pready ##1 !o_pready)
    else $error("pready not a single pulse");
  chk_apb_unmap: assert property (access && !hit_any |=> o_pslverr &&
    o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_scale_latch: assert property (restart |=>
    abs_ff == (sel_ff[gms_pkg::SEL_SCALE_LSB +: 4] == 4'h1))
    else $error("scale type not taken at restart");
  chk_mode_test: assert property (test_ff && !gear_err |=>
    mode_ff == gms_pkg::MD_TEST)
    else $error("test mode not entered");
  chk_regen_pass: assert property (!test_ff |=>
    o_regen_en == $past(i_regen_req))
    else $error("regeneration request not passed");
  chk_dir_shown: assert property (!test_ff |=> o_dir_valid)
    else $error("direction hidden outside test");

  // the lost flag must record a link drop during test, and only restart may clear it
  chk_lost_clear: assert property (restart |=> !link_lost_ff)
    else $error("restart did not clear lost link");
  chk_lost_set: assert property (test_ff && !link_lvl && !restart |=>
    link_lost_ff)
    else $error("dropped link not recorded");
endmodule : gms_top

// ===== tb/gms_host.sv
// host controller model issuing reference pulse trains
`timescale 1ns/100ps
module gms_host (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  input  wire logic       i_dir,
  output logic            o_ref_pulse,
  output logic            o_ref_dir,
  output logic            o_busy
);
  logic [7:0] left_ff  = 8'h00;
  logic [3:0] ph_ff    = 4'h0;
  logic       pulse_ff = 1'b0;
  logic       dir_ff   = 1'b1;

  assign o_busy      = (left_ff != 8'h00);
  assign o_ref_pulse = pulse_ff;
  assign o_ref_dir   = dir_ff;

  // 8 high, 8 low: slow enough for the steps of one unit to drain
  // direction only moves at start, while the pulse line is low
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      left_ff <= i_count;
      ph_ff   <= 4'h0;
      dir_ff  <= i_dir;
    end else if (o_busy) begin
      ph_ff    <= ph_ff + 4'h1;
      pulse_ff <= (ph_ff < 4'h8);
      if (ph_ff == 4'hF) begin
        left_ff <= left_ff - 8'h01;
      end
    end else begin
      pulse_ff <= 1'b0;
    end
  end
endmodule : gms_host

// ===== tb/tb_gms_top.sv
// self-checking bench for the gear scaler and motorless test block
`timescale 1ns/100ps
module tb_gms_top;
  logic        i_clk   = 1'b0;
  logic        i_srst  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        enc_link = 1'b0;
  logic        enc_dir  = 1'b0;
  logic        regen = 1'b0;
  logic        dbrake = 1'b0;
  logic        brake = 1'b0;
  logic        h_start = 1'b0;
  logic        h_dir = 1'b1;
  logic [7:0]  h_cnt = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, ref_pulse, ref_dir, h_busy;
  logic        fb_step, fb_dir, sim, sabs, alarm, drive_en;
  logic        regen_en, dbrake_en, brake_out, dir_valid, dir, fn_start;
  logic [11:0] fn_code;
  logic [11:0] last_code = 12'h000;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          step_cnt = 0;
  int          fn_cnt = 0;
  int          cyc = 0;
  logic [11:0] codes [12] = '{12'h200, 12'h201, 12'h207, 12'h01B, 12'h080,
    12'h008, 12'h00E, 12'h00F, 12'h020, 12'h000, 12'h030, 12'h002};
  logic [31:0] gnum [4] = '{32'd1, 32'd1, 32'd4000, 32'd4001};
  logic [31:0] gden [4] = '{32'd1000, 32'd1001, 32'd1, 32'd1};

  gms_host i_host (.i_clk(i_clk), .i_start(h_start), .i_count(h_cnt),
    .i_dir(h_dir), .o_ref_pulse(ref_pulse), .o_ref_dir(ref_dir),
    .o_busy(h_busy));

  gms_top i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ref_pulse(ref_pulse), .i_ref_dir(ref_dir),
    .i_enc_link(enc_link), .i_enc_dir(enc_dir), .i_regen_req(regen),
    .i_dbrake_req(dbrake), .i_brake_req(brake), .o_fb_step(fb_step),
    .o_fb_dir(fb_dir), .o_sim_active(sim), .o_scale_abs(sabs),
    .o_alarm(alarm), .o_drive_en(drive_en), .o_regen_en(regen_en),
    .o_dbrake_en(dbrake_en), .o_brake_out(brake_out),
    .o_dir_valid(dir_valid), .o_dir(dir), .o_fn_start(fn_start),
    .o_fn_code(fn_code));

  always #2 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (fb_step === 1'b1) step_cnt++;
    if (fn_start === 1'b1) fn_cnt++;
    cyc++;
    // ceiling well above the roughly 5200 cycles the sequence needs
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // entered just after a rising edge; leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(name, rd, exp);
  endtask : rdc

  task automatic restart;
    wr(gms_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (8) @(posedge i_clk);
  endtask : restart

  task automatic run(input logic [7:0] n, input logic d, input int exp);
    int k;
    k = 0;
    step_cnt = 0;
    h_dir   <= d;
    h_cnt   <= n;
    h_start <= 1'b1;
    @(posedge i_clk);
    h_start <= 1'b0;
    @(posedge i_clk);
    while (h_busy === 1'b1 && k < 5000) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 5000) error_cnt++;
    repeat (exp + 40) @(posedge i_clk);
    check("fb_steps", step_cnt, exp);
  endtask : run

  task automatic fn(input logic [11:0] code, input logic ok);
    int c0;
    c0 = fn_cnt;
    wr(gms_pkg::OFS_FN_REQ, {20'h0_0000, code});
    repeat (2) @(posedge i_clk);
    if (ok) last_code = code;
    check("fn_start", fn_cnt - c0, {31'h0000_0000, ok});
    check("fn_code", {20'h0_0000, fn_code}, {20'h0_0000, last_code});
    rdc("fn_req", gms_pkg::OFS_FN_REQ,
        {18'h0_0000, ok ? 2'h1 : 2'h2, last_code});
  endtask : fn

  initial begin
    logic [31:0] rd;
    logic        err;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rdc("num", gms_pkg::OFS_GEAR_NUM, 32'h0000_0004);
    rdc("den", gms_pkg::OFS_GEAR_DEN, 32'h0000_0001);
    rdc("sel", gms_pkg::OFS_APP_SEL, 32'h0000_0000);
    rdc("status", gms_pkg::OFS_STATUS, 32'h0000_0000);
    check("drive_en", drive_en, 1);
    // unmapped place: refused, and nothing else moves
    wr(8'h18, 32'h0000_0077);
    apb(1'b0, 8'h18, 32'h0000_0000, rd, err);
    check("unmapped_err", err, 1);
    check("unmapped_rd", rd, 0);
    rdc("num", gms_pkg::OFS_GEAR_NUM, 32'h0000_0004);
    // 256 x 1 um unit over 20 um pitch
    wr(gms_pkg::OFS_GEAR_NUM, 32'h0000_0100);
    wr(gms_pkg::OFS_GEAR_DEN, 32'h0000_0014);
    run(8'd1, 1'b1, 4);
    restart();
    run(8'd1, 1'b1, 12);
    run(8'd4, 1'b1, 52);
    check("fb_dir", fb_dir, 1);
    run(8'd5, 1'b0, 64);
    check("fb_dir", fb_dir, 0);
    for (int i = 0; i < 4; i++) begin
      wr(gms_pkg::OFS_GEAR_NUM, gnum[i]);
      wr(gms_pkg::OFS_GEAR_DEN, gden[i]);
      restart();
      check("alarm", alarm, i % 2);
      check("drive_en", drive_en, 1 - i % 2);
      rdc("status", gms_pkg::OFS_STATUS, (i % 2) * 32'h44);
      run(8'd1, 1'b1, (i % 2) ? 0 : gnum[i] / gden[i]);
    end
    wr(gms_pkg::OFS_GEAR_NUM, 32'h0000_0100);
    wr(gms_pkg::OFS_GEAR_DEN, 32'h0000_0014);
    // test without a motor, absolute scale
    wr(gms_pkg::OFS_APP_SEL, 32'h0000_0101);
    check("sim_before", sim, 0);
    restart();
    check("sim", sim, 1);
    check("scale_abs", sabs, 1);
    regen  <= 1'b1;
    dbrake <= 1'b1;
    brake  <= 1'b1;
    repeat (3) @(posedge i_clk);
    check("regen", regen_en, 0);
    check("dbrake", dbrake_en, 0);
    check("brake", brake_out, 0);
    check("drive_en", drive_en, 0);
    check("dir_valid", dir_valid, 0);
    check("dir", dir, 0);
    run(8'd1, 1'b1, 12);
    for (int i = 0; i < 12; i++) begin
      fn(codes[i], i >= 9);
    end
    // test with a motor attached, incremental scale
    enc_link <= 1'b1;
    enc_dir  <= 1'b1;
    wr(gms_pkg::OFS_APP_SEL, 32'h0000_0001);
    restart();
    check("scale_abs", sabs, 0);
    rdc("status", gms_pkg::OFS_STATUS, 32'h0000_0029);
    check("dir_valid", dir_valid, 1);
    check("dir", dir, 1);
    fn(12'h008, 1'b1);
    fn(12'h200, 1'b0);
    enc_link <= 1'b0;
    repeat (6) @(posedge i_clk);
    enc_link <= 1'b1;
    repeat (6) @(posedge i_clk);
    rdc("status", gms_pkg::OFS_STATUS, 32'h0000_0031);
    fn(12'h020, 1'b0);
    fn(12'h000, 1'b1);
    // back to normal running
    wr(gms_pkg::OFS_APP_SEL, 32'h0000_0000);
    restart();
    check("sim", sim, 0);
    check("regen", regen_en, 1);
    check("dbrake", dbrake_en, 1);
    check("brake", brake_out, 1);
    check("dir_valid", dir_valid, 1);
    fn(12'h200, 1'b1);
    end_of_test();
  end
endmodule : tb_gms_top
